// File: tb/afe_modulator_delay_gain_regs_test.sv
`timescale 1ns/1ps
module afe_modulator_delay_gain_regs_test;
  import afe_regs_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic [3:0] cmp_a = '0;
  logic [3:0] cmp_b = '0;
  logic [2:0] osr = '0;
  reg_req_t req;
  logic [7:0] rdata, snap;
  logic rd_valid, restart, lag_b;
  logic [11:0] delay;
  logic [1:0] bias;
  logic [2:0] code_a, code_b;
  logic [5:0] mult_a, mult_b;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  initial forever #12.5 clk = ~clk;

  serial_host host (.clk(clk), .req(req));
  afe_modulator_delay_gain_regs dut (.clk(clk), .rstn(rstn), .req(req),
    .comparator_bits_ch_a(cmp_a), .comparator_bits_ch_b(cmp_b), .osr_code(osr),
    .rdata(rdata), .rd_valid(rd_valid), .comparator_snapshot(snap),
    .channel_delay(delay), .bias_select(bias), .amp_gain_code_ch_a(code_a),
    .amp_gain_code_ch_b(code_b), .gain_mult_ch_a(mult_a), .gain_mult_ch_b(mult_b),
    .converter_restart(restart), .lagging_is_ch_b(lag_b));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic test_done;
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic reset_values;
    check("snapshot", snap, 12'h033);
    check("delay", delay, 12'h000);
    check("bias", bias, 12'h2);
    check("code_a", code_a, 12'h0);
    check("code_b", code_b, 12'h0);
    check("mult_a", mult_a, 12'h1);
    check("mult_b", mult_b, 12'h1);
    check("restart", restart, 12'h0);
    check("lag", lag_b, 12'h1);
    check("rd_valid", rd_valid, 12'h0);
    check("rdata", rdata, 12'h000);
  endtask : reset_values

  // Read results matched against the oldest note
  always @(negedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      num_errors++;
      test_done();
    end else if (rd_valid === 1'b1) begin
      check("rdata", rdata, exp_q.size() > 0 ? {4'h0, exp_q.pop_front()} : 12'hfff);
    end
  end

  initial begin
    logic [7:0] v;
    logic [5:0] mult_tab [8];
    mult_tab = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01, 6'h01};
    void'($urandom(32'h9143));
    repeat (8) @(negedge clk);
    reset_values();
    rstn <= 1'b1;
    rd(GAIN_ADDR, 8'h80);
    rd(DELAY_HI_ADDR, 8'h00);
    rd(DELAY_LO_ADDR, 8'h00);
    host.access(1'b1, DELAY_HI_ADDR, 8'hff);
    check("restart", restart, 12'h1);
    check("delay", delay, 12'hf00);
    check("lag", lag_b, 12'h0);
    rd(DELAY_HI_ADDR, 8'h0f);
    check("restart", restart, 12'h0);
    osr <= 3'($urandom);
    v = 8'($urandom_range(15, 1));
    host.access(1'b1, DELAY_HI_ADDR, 8'h00);
    host.access(1'b1, DELAY_LO_ADDR, v);
    check("restart", restart, 12'h1);
    check("delay", delay, {4'h0, v});
    @(negedge clk);
    check("lag", lag_b, 12'h0);
    host.access(1'b1, DELAY_HI_ADDR, 8'h0f);
    host.access(1'b1, DELAY_LO_ADDR, 8'hff);
    check("delay", delay, 12'hfff);
    check("lag", lag_b, 12'h1);
    // Largest positive delay passes half a frame unless the ratio is the top one
    host.access(1'b1, DELAY_HI_ADDR, 8'h07);
    check("lag", lag_b, {11'h0, osr != 3'h7});
    for (int c = 0; c < 8; c++) begin
      v = {2'($urandom), 3'(c), 3'(7 - c)};
      host.access(1'b1, GAIN_ADDR, v);
      check("mult_b", mult_b, mult_tab[c]);
      check("mult_a", mult_a, mult_tab[7 - c]);
      check("bias", bias, {10'h0, v[7:6]});
      check("code_b", code_b, 12'(c));
      check("code_a", code_a, 12'(7 - c));
      rd(GAIN_ADDR, v);
    end
    // Reset in mid-run returns every field to its reset value
    @(negedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    reset_values();
    rstn <= 1'b1;
    rd(DELAY_LO_ADDR, 8'h00);
    rd(5'h1f, 8'h00);
    v = 8'($urandom);
    host.access(1'b1, SNAPSHOT_ADDR, v);
    check("snapshot", snap, {4'h0, v});
    @(negedge clk);
    check("snapshot", snap, {4'h0, cmp_b, cmp_a});
    repeat (8) begin
      cmp_a <= 4'($urandom);
      cmp_b <= 4'($urandom);
      @(negedge clk);
      check("snapshot", snap, {cmp_b, cmp_a});
    end
    repeat (2) @(negedge clk);
    check("pending", 12'(exp_q.size()), 12'h0);
    test_done();
  end
endmodule : afe_modulator_delay_gain_regs_test

// File: tb/serial_host.sv
`timescale 1ns/1ps
module serial_host
  import afe_regs_pkg::*;
(
  input wire logic clk, // Device clock
  output reg_req_t req // Register access
);
  initial req = '0;
  // One access per call, request held across exactly one rising edge
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask : access
endmodule : serial_host

// File: verilog/afe_modulator_delay_gain_regs.sv
// Function
// - Channel b comparator bits in snapshot 7:4
// - Channel a comparator bits in snapshot 3:0
// - Delay byte write restarts the converters
// - Twelve-bit signed delay, resets to zero
// - Delay bits 15:12 ignore writes, read zero
// - Shared bias field bits 7:6, resets 10
// - Channel b gain code, same encoding, reset 000
// - Lagging channel from delay and oversampling ratio
`timescale 1ns/1ps
module afe_modulator_delay_gain_regs
  import afe_regs_pkg::*;
(
  input wire logic clk, // 40 MHz device clock
  input wire logic rstn, // Async reset, active low
  input wire reg_req_t req, // Byte register access from serial port
  input wire logic [COMP_W-1:0] comparator_bits_ch_a, // Live comparators, channel 0
  input wire logic [COMP_W-1:0] comparator_bits_ch_b, // Live comparators, channel 1
  input wire logic [OSR_W-1:0] osr_code, // Oversampling ratio select
  output logic [DATA_W-1:0] rdata, // Read data
  output logic rd_valid, // Read data valid pulse
  output logic [DATA_W-1:0] comparator_snapshot, // Snapshot register
  output logic [DELAY_W-1:0] channel_delay, // Signed delay in modulator_clock periods
  output logic [1:0] bias_select, // Bias current select
  output logic [CODE_W-1:0] amp_gain_code_ch_a, // Gain code channel 0
  output logic [CODE_W-1:0] amp_gain_code_ch_b, // Gain code channel 1
  output logic [MULT_W-1:0] gain_mult_ch_a, // Decoded gain channel 0
  output logic [MULT_W-1:0] gain_mult_ch_b, // Decoded gain channel 1
  output logic converter_restart, // One-cycle restart pulse
  output logic lagging_is_ch_b // High when channel 1 lags
);

  regs_state_t st_reg;
  regs_state_t st_next;

  function automatic logic [MULT_W-1:0] gain_of(input logic [CODE_W-1:0] code);
    unique case (code)
      CODE_X2: gain_of = 6'h02;
      CODE_X4: gain_of = 6'h04;
      CODE_X8: gain_of = 6'h08;
      CODE_X16: gain_of = 6'h10;
      CODE_X32: gain_of = 6'h20;
      default: gain_of = MULT_ONE;
    endcase
  endfunction : gain_of

  function automatic logic lag_of(input logic [DELAY_W-1:0] d, input logic [OSR_W-1:0] o);
    logic [DELAY_W:0] mag;
    logic [DELAY_W:0] half;
    mag = d[DELAY_W-1] ? {1'b0, (~d + 12'h001)} : {1'b0, d};
    half = OSR_HALF_MIN << o;
    // Positive delay holds channel a back, unless it reaches half a frame
    lag_of = (d == DELAY_RST) ? 1'b1 : (d[DELAY_W-1] ^ (mag >= half));
  endfunction : lag_of

  wire logic wr_delay;
  assign wr_delay = req.wr && (req.addr == DELAY_HI_ADDR || req.addr == DELAY_LO_ADDR);

  always_comb begin
    st_next = st_reg;
    st_next.snapshot = {comparator_bits_ch_b, comparator_bits_ch_a};
    st_next.restart = wr_delay;
    st_next.rd_valid = req.rd;
    st_next.rdata = st_reg.rdata;
    if (req.wr) begin
      unique case (req.addr)
        SNAPSHOT_ADDR: st_next.snapshot = req.wdata;
        DELAY_HI_ADDR: st_next.delay[DELAY_W-1:DATA_W] = req.wdata[DELAY_HI_W-1:0];
        DELAY_LO_ADDR: st_next.delay[DATA_W-1:0] = req.wdata;
        GAIN_ADDR: begin
          st_next.bias = req.wdata[BIAS_LSB +: 2];
          st_next.code_b = req.wdata[CODE_B_LSB +: CODE_W];
          st_next.code_a = req.wdata[CODE_A_LSB +: CODE_W];
        end
        default: ;
      endcase
    end
    st_next.mult_a = gain_of(st_next.code_a);
    st_next.mult_b = gain_of(st_next.code_b);
    st_next.lag_is_b = lag_of(st_next.delay, osr_code);
    if (req.rd) begin
      unique case (req.addr)
        SNAPSHOT_ADDR: st_next.rdata = st_reg.snapshot;
        DELAY_HI_ADDR: st_next.rdata = {{(DATA_W-DELAY_HI_W){1'b0}},
                                        st_reg.delay[DELAY_W-1:DATA_W]};
        DELAY_LO_ADDR: st_next.rdata = st_reg.delay[DATA_W-1:0];
        GAIN_ADDR: st_next.rdata = {st_reg.bias, st_reg.code_b, st_reg.code_a};
        default: st_next.rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg.snapshot <= SNAPSHOT_RST;
      st_reg.delay <= DELAY_RST;
      st_reg.bias <= BIAS_RST;
      st_reg.code_a <= CODE_RST;
      st_reg.code_b <= CODE_RST;
      st_reg.mult_a <= MULT_ONE;
      st_reg.mult_b <= MULT_ONE;
      st_reg.restart <= 1'b0;
      st_reg.lag_is_b <= 1'b1;
      st_reg.rdata <= READ_ZERO;
      st_reg.rd_valid <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign rd_valid = st_reg.rd_valid;
  assign comparator_snapshot = st_reg.snapshot;
  assign channel_delay = st_reg.delay;
  assign bias_select = st_reg.bias;
  assign amp_gain_code_ch_a = st_reg.code_a;
  assign amp_gain_code_ch_b = st_reg.code_b;
  assign gain_mult_ch_a = st_reg.mult_a;
  assign gain_mult_ch_b = st_reg.mult_b;
  assign converter_restart = st_reg.restart;
  assign lagging_is_ch_b = st_reg.lag_is_b;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Snapshot follows the comparators except in the cycle after a host write to the snapshot address
  snap_ch_b_a: assert property (!(req.wr && req.addr == SNAPSHOT_ADDR) |=>
    comparator_snapshot[DATA_W-1:COMP_W] == $past(comparator_bits_ch_b))
    else $error("channel b snapshot mismatch");
  snap_ch_a_a: assert property (!(req.wr && req.addr == SNAPSHOT_ADDR) |=>
    comparator_snapshot[COMP_W-1:0] == $past(comparator_bits_ch_a))
    else $error("channel a snapshot mismatch");
  snap_read_a: assert property (req.rd && req.addr == SNAPSHOT_ADDR |=>
    rdata == $past(comparator_snapshot))
    else $error("snapshot read mismatch");

  // Restart is a pulse tied to delay writes only
  restart_pulse_a: assert property (wr_delay |=>
    converter_restart)
    else $error("delay write gave no restart");
  restart_quiet_a: assert property (!wr_delay |=>
    !converter_restart)
    else $error("restart held without delay write");
  restart_cause_a: assert property ($rose(converter_restart) |->
    $past(wr_delay))
    else $error("restart without delay write");

  delay_low_a: assert property (req.wr && req.addr == DELAY_LO_ADDR |=>
    channel_delay[DATA_W-1:0] == $past(req.wdata))
    else $error("delay low byte not stored");
  delay_high_a: assert property (req.wr && req.addr == DELAY_HI_ADDR |=>
    channel_delay[DELAY_W-1:DATA_W] == $past(req.wdata[DELAY_HI_W-1:0]))
    else $error("delay high nibble not stored");
  delay_hold_a: assert property (!wr_delay |=>
    $stable(channel_delay))
    else $error("delay changed without a write");
  delay_top_a: assert property (req.rd && req.addr == DELAY_HI_ADDR |=>
    rd_valid && rdata[DATA_W-1:DELAY_HI_W] == 4'h0)
    else $error("delay upper bits not zero");

  bias_write_a: assert property (req.wr && req.addr == GAIN_ADDR |=>
    bias_select == $past(req.wdata[BIAS_LSB +: 2]))
    else $error("bias field not stored");
  bias_hold_a: assert property (!(req.wr && req.addr == GAIN_ADDR) |=>
    $stable(bias_select))
    else $error("bias changed without a write");
  gain_read_a: assert property (req.rd && req.addr == GAIN_ADDR |=>
    rdata == {$past(bias_select), $past(amp_gain_code_ch_b), $past(amp_gain_code_ch_a)})
    else $error("gain register read mismatch");
  code_a_write_a: assert property (req.wr && req.addr == GAIN_ADDR |=>
    amp_gain_code_ch_a == $past(req.wdata[CODE_A_LSB +: CODE_W]))
    else $error("channel a gain code not stored");
  code_b_write_a: assert property (req.wr && req.addr == GAIN_ADDR |=>
    amp_gain_code_ch_b == $past(req.wdata[CODE_B_LSB +: CODE_W]))
    else $error("channel b gain code not stored");

  // Decoded gain stands in the same cycle as its code
  gain_one_a: assert property (amp_gain_code_ch_a == CODE_RST |->
    gain_mult_ch_a == MULT_ONE)
    else $error("channel a gain 1 wrong");
  gain_a_decode_a: assert property (amp_gain_code_ch_a == CODE_X32 |->
    gain_mult_ch_a == 6'h20)
    else $error("channel a gain 32 wrong");
  gain_a_resv_a: assert property (amp_gain_code_ch_a[CODE_W-1:1] == 2'h3 |->
    gain_mult_ch_a == MULT_ONE)
    else $error("channel a reserved gain wrong");
  gain_x16_a: assert property (amp_gain_code_ch_b == CODE_X16 |->
    gain_mult_ch_b == 6'h10)
    else $error("channel b gain 16 wrong");
  gain_b_top_a: assert property (amp_gain_code_ch_b == CODE_X32 |->
    gain_mult_ch_b == 6'h20)
    else $error("channel b gain 32 wrong");
  gain_b_resv_a: assert property (amp_gain_code_ch_b[CODE_W-1:1] == 2'h3 |->
    gain_mult_ch_b == MULT_ONE)
    else $error("channel b reserved gain wrong");
  gain_x2_a: assert property (amp_gain_code_ch_a == CODE_X2 |->
    gain_mult_ch_a == 6'h02)
    else $error("channel a gain 2 wrong");
  gain_mid_a: assert property (amp_gain_code_ch_a == CODE_X4 |->
    gain_mult_ch_a == 6'h04)
    else $error("channel a gain 4 wrong");
  gain_x8_a: assert property (amp_gain_code_ch_b == CODE_X8 |->
    gain_mult_ch_b == 6'h08)
    else $error("channel b gain 8 wrong");

  // Small delays never reach half a frame, whatever the ratio
  lag_zero_a: assert property (channel_delay == DELAY_RST |->
    lagging_is_ch_b)
    else $error("zero delay must lag channel b");
  lag_sign_a: assert property (!channel_delay[DELAY_W-1] && channel_delay != DELAY_RST &&
    channel_delay < 12'h010 |-> !lagging_is_ch_b)
    else $error("small positive delay must lag channel a");
  lag_neg_a: assert property (channel_delay[DELAY_W-1] && channel_delay > 12'hff0 |->
    lagging_is_ch_b)
    else $error("small negative delay must lag channel b");

  read_pulse_a: assert property (req.rd |=>
    rd_valid)
    else $error("read gave no valid pulse");
  read_idle_a: assert property (!req.rd |=>
    !rd_valid)
    else $error("valid pulse without a read");
  unmapped_read_a: assert property (req.rd && (req.addr < SNAPSHOT_ADDR || req.addr > GAIN_ADDR)
    |=> rdata == READ_ZERO)
    else $error("unmapped read not zero");

  delay_write_c: cover property (wr_delay ##1 converter_restart);
  gain_write_c: cover property (req.wr && req.addr == GAIN_ADDR ##1 gain_mult_ch_b == 6'h20);
  snap_read_c: cover property (req.rd && req.addr == SNAPSHOT_ADDR ##1 rd_valid);
  lag_flip_c: cover property (lagging_is_ch_b ##1 !lagging_is_ch_b);
  snap_write_c: cover property (req.wr && req.addr == SNAPSHOT_ADDR ##1
    comparator_snapshot == $past(req.wdata));

endmodule : afe_modulator_delay_gain_regs

// File: verilog/afe_regs_pkg.sv
package afe_regs_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int DELAY_W = 12;
  localparam int COMP_W = 4;
  localparam int CODE_W = 3;
  localparam int MULT_W = 6;
  localparam int OSR_W = 3;

  // Byte addresses on the serial register port
  localparam logic [ADDR_W-1:0] SNAPSHOT_ADDR = 5'h06;
  localparam logic [ADDR_W-1:0] DELAY_HI_ADDR = 5'h07;
  localparam logic [ADDR_W-1:0] DELAY_LO_ADDR = 5'h08;
  localparam logic [ADDR_W-1:0] GAIN_ADDR = 5'h09;

  // Field positions
  localparam int BIAS_LSB = 6;
  localparam int CODE_B_LSB = 3;
  localparam int CODE_A_LSB = 0;
  localparam int DELAY_HI_W = DELAY_W - DATA_W;

  // Reset values
  localparam logic [DATA_W-1:0] SNAPSHOT_RST = 8'h33;
  localparam logic [DELAY_W-1:0] DELAY_RST = 12'h000;
  localparam logic [1:0] BIAS_RST = 2'h2;
  localparam logic [CODE_W-1:0] CODE_RST = 3'h0;
  localparam logic [MULT_W-1:0] MULT_ONE = 6'h01;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Amplifier gain codes
  localparam logic [CODE_W-1:0] CODE_X2 = 3'h1;
  localparam logic [CODE_W-1:0] CODE_X4 = 3'h2;
  localparam logic [CODE_W-1:0] CODE_X8 = 3'h3;
  localparam logic [CODE_W-1:0] CODE_X16 = 3'h4;
  localparam logic [CODE_W-1:0] CODE_X32 = 3'h5;

  // Half of the smallest oversampling ratio, in modulator clock periods
  localparam logic [DELAY_W:0] OSR_HALF_MIN = 13'h0010;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] snapshot;
    logic [DELAY_W-1:0] delay;
    logic [1:0] bias;
    logic [CODE_W-1:0] code_a;
    logic [CODE_W-1:0] code_b;
    logic [MULT_W-1:0] mult_a;
    logic [MULT_W-1:0] mult_b;
    logic restart;
    logic lag_is_b;
    logic [DATA_W-1:0] rdata;
    logic rd_valid;
  } regs_state_t;

endpackage : afe_regs_pkg
